//--- rtl/mic_cfg.svh
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// register byte offsets
`define MIC_OFF_CONTROL   4'h0
`define MIC_OFF_PFLAGS    4'h4
`define MIC_OFF_PENABLE   4'h8
`define MIC_OFF_OPTION    4'hC

// control register fields
`define MIC_GLOBAL_EN_BIT 7
`define MIC_GROUP_EN_BIT  6
`define MIC_T8E_BIT       5
`define MIC_EXTE_BIT      4
`define MIC_PCE_BIT       3
`define MIC_T8F_BIT       2
`define MIC_EXTF_BIT      1
`define MIC_PCF_BIT       0

// peripheral flag / enable fields
`define MIC_EE_BIT        7
`define MIC_AD_BIT        6
`define MIC_CMP_BIT       3
`define MIC_T16_BIT       0
`define MIC_PERIPH_MASK   8'h_C9

// option register: edge select
`define MIC_EDGE_BIT      0

// reset values
`define MIC_CONTROL_RST   8'h00
`define MIC_PERIPH_RST    8'h00
`define MIC_EDGE_RST      1'b1

// vector and service latency
`define MIC_VECTOR        13'h0004
`define MIC_LATENCY_CYC   3

`endif

//--- rtl/mic_pkg.sv
package mic_pkg;
  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_WAIT,
    MIC_VECT
  } mic_state_t;

  typedef logic [12:0] mic_pc_t;
endpackage

//--- rtl/mic_edge_detect.sv
`timescale 1ns/1ps
`include "mic_cfg.svh"

module mic_edge_detect (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and polarity
  input  wire logic pin,
  input  wire logic rising,
  // detected edge
  output logic      edge_seen
);
  logic last_level;
  logic primed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_level <= 1'b0;
      primed     <= 1'b0;
      edge_seen  <= 1'b0;
    end else begin
      // no edge on the first cycle: pin level before reset is unknown
      last_level <= pin;
      primed     <= 1'b1;
      edge_seen  <= primed & (rising ? (pin & ~last_level) : (~pin & last_level));
    end
  end
endmodule

//--- rtl/mic_irq_ctrl.sv
// Function
// - seven request sources collected
// - global enable gates all requests
// - reset clears global enable
// - return instruction sets global enable
// - per-source enable masks each source
// - control register holds ext, port, timer8 flags
// - peripheral flags and enables in own registers
// - take: clear global, push, load vector
// - pin events reach vector in 3-4 cycles
// - flags set regardless of enables
// - global clear cancels imminent take
// - wake-up loads vector when global set
// - peripheral flag bits show wake cause
// - external pin edge-selectable, sets control bit 1
// - timer8 rollover sets control bit 2
// - selected port change sets control bit 0
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "mic_cfg.svh"

module mic_irq_ctrl (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // axi4-lite read data
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // request sources
  input  wire logic                 ext_irq_pin,
  input  wire logic [7:0]           timer8_count,
  input  wire logic [5:0]           port_pins,
  input  wire logic [5:0]           change_detect_select,
  input  wire logic                 cmp_change,
  input  wire logic                 adc_done,
  input  wire logic                 timer16_overflow,
  input  wire logic                 eeprom_write_done,
  // core sequencer
  input  wire logic                 return_from_irq,
  input  wire logic                 core_sleeping,
  input  wire logic [12:0]          core_pc,
  output logic                      irq_take,
  output logic                      stack_push,
  output mic_pkg::mic_pc_t          stack_push_data,
  output logic                      pc_load,
  output mic_pkg::mic_pc_t          pc_load_value,
  output logic                      wake_up,
  output logic                      irq
);
  import mic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]  irq_control_reg;
  logic [7:0]  periph_irq_flags;
  logic [7:0]  periph_irq_enables;
  logic        ext_edge_select;
  logic [7:0]  last_timer;
  logic [5:0]  last_port;
  logic [1:0]  wait_cnt;
  mic_state_t  state;
  mic_state_t  next_state;
  logic        ext_edge;

  mic_edge_detect u_ext_edge (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (ext_irq_pin),
    .rising    (ext_edge_select),
    .edge_seen (ext_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  wire timer8_roll  = (last_timer == 8'h_FF) && (timer8_count == 8'h_00);
  wire port_change  = |((port_pins ^ last_port) & change_detect_select);
  wire [7:0] ctl_ev = {5'b0, timer8_roll, ext_edge, port_change};
  wire [7:0] per_ev = {eeprom_write_done, adc_done, 2'b0, cmp_change, 2'b0,
                       timer16_overflow} & `MIC_PERIPH_MASK;

  wire ctl_pending = |(irq_control_reg[2:0] & irq_control_reg[5:3]);
  wire per_pending = |(periph_irq_flags & periph_irq_enables)
                     & irq_control_reg[`MIC_GROUP_EN_BIT];
  wire any_pending = ctl_pending | per_pending;
  wire global_irq_enable = irq_control_reg[`MIC_GLOBAL_EN_BIT];
  wire can_take    = any_pending & global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave decode
  // one accept per request; a held valid writes again only after its response is taken
  wire wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire rd_go  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire wr_ctl = wr_go & (s_axi_awaddr == `MIC_OFF_CONTROL) & s_axi_wstrb[0];
  wire wr_pfl = wr_go & (s_axi_awaddr == `MIC_OFF_PFLAGS) & s_axi_wstrb[0];
  wire wr_pen = wr_go & (s_axi_awaddr == `MIC_OFF_PENABLE) & s_axi_wstrb[0];
  wire wr_opt = wr_go & (s_axi_awaddr == `MIC_OFF_OPTION) & s_axi_wstrb[0];
  wire wr_hit = (s_axi_awaddr == `MIC_OFF_CONTROL) | (s_axi_awaddr == `MIC_OFF_PFLAGS)
              | (s_axi_awaddr == `MIC_OFF_PENABLE) | (s_axi_awaddr == `MIC_OFF_OPTION);
  wire [7:0] wbyte = s_axi_wdata[7:0];

  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == `MIC_OFF_CONTROL) begin
      rd_mux = irq_control_reg;
    end else if (s_axi_araddr == `MIC_OFF_PFLAGS) begin
      rd_mux = periph_irq_flags;
    end else if (s_axi_araddr == `MIC_OFF_PENABLE) begin
      rd_mux = periph_irq_enables;
    end else if (s_axi_araddr == `MIC_OFF_OPTION) begin
      rd_mux = {7'b0, ext_edge_select};
    end else begin
      rd_mux = 8'h_00;
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // take sequencer: models the pin-to-vector latency
  wire cancel = wr_ctl & ~wbyte[`MIC_GLOBAL_EN_BIT];

  always_comb begin
    next_state = state;
    case (state)
      MIC_RUN: begin
        if (can_take & ~cancel) begin
          next_state = MIC_WAIT;
        end
      end
      MIC_WAIT: begin
        // pending stays latched, so a cancelled take resumes on re-enable
        if (~global_irq_enable | cancel) begin
          next_state = MIC_RUN;
        // wait spans the latency less the vector and output cycles
        end else if (wait_cnt == 2'(`MIC_LATENCY_CYC - 3)) begin
          next_state = MIC_VECT;
        end
      end
      MIC_VECT: begin
        next_state = MIC_RUN;
      end
      default: begin
        next_state = MIC_RUN;
      end
    endcase
  end

  wire take_now = (state == MIC_VECT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= MIC_RUN;
      wait_cnt <= 2'd0;
    end else begin
      state    <= next_state;
      wait_cnt <= (state == MIC_WAIT) ? wait_cnt + 2'd1 : 2'd0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag and enable registers
  logic [7:0] next_ctl;
  logic [7:0] next_pfl;
  always_comb begin
    next_ctl = irq_control_reg;
    if (wr_ctl) begin
      next_ctl = wbyte;
    end
    next_ctl = next_ctl | ctl_ev;
    if (take_now) begin
      next_ctl[`MIC_GLOBAL_EN_BIT] = 1'b0;
    end else if (return_from_irq) begin
      next_ctl[`MIC_GLOBAL_EN_BIT] = 1'b1;
    end
    next_pfl = periph_irq_flags;
    if (wr_pfl) begin
      next_pfl = wbyte & `MIC_PERIPH_MASK;
    end
    next_pfl = next_pfl | per_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_reg    <= `MIC_CONTROL_RST;
      periph_irq_flags   <= `MIC_PERIPH_RST;
      periph_irq_enables <= `MIC_PERIPH_RST;
      ext_edge_select    <= `MIC_EDGE_RST;
      last_timer         <= 8'h_00;
      last_port          <= 6'h_00;
    end else begin
      irq_control_reg <= next_ctl;
      periph_irq_flags <= next_pfl;
      if (wr_pen) begin
        periph_irq_enables <= wbyte & `MIC_PERIPH_MASK;
      end
      if (wr_opt) begin
        ext_edge_select <= wbyte[`MIC_EDGE_BIT];
      end
      last_timer <= timer8_count;
      last_port  <= port_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core-facing outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_take        <= 1'b0;
      stack_push      <= 1'b0;
      stack_push_data <= 13'h0;
      pc_load         <= 1'b0;
      pc_load_value   <= 13'h0;
      wake_up         <= 1'b0;
      irq             <= 1'b0;
    end else begin
      irq_take        <= take_now;
      stack_push      <= take_now;
      stack_push_data <= core_pc;
      pc_load         <= take_now;
      pc_load_value   <= `MIC_VECTOR;
      // sleep wake needs only flag and enable; vector follows if global set
      wake_up         <= core_sleeping & any_pending;
      irq             <= any_pending & global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h_0000_0000;
    end else begin
      s_axi_awready <= wr_go & ~s_axi_awready;
      s_axi_wready  <= wr_go & ~s_axi_awready;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go & ~s_axi_awready) begin
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end
      s_axi_arready <= rd_go & ~s_axi_arready;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go & ~s_axi_arready) begin
        s_axi_rdata <= {24'h00_0000, rd_mux};
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end
    end
  end
endmodule

//--- testbench/mic_irq_ctrl_props.sv
`timescale 1ns/1ps
`include "mic_cfg.svh"
module mic_irq_ctrl_props (
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  // core
  input wire logic             return_from_irq,
  input wire logic             core_sleeping,
  input wire logic             irq_take,
  input wire logic             stack_push,
  input wire mic_pkg::mic_pc_t stack_push_data,
  input wire mic_pkg::mic_pc_t core_pc,
  input wire logic             pc_load,
  input wire mic_pkg::mic_pc_t pc_load_value,
  input wire logic             wake_up,
  input wire logic             irq
);
  import mic_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // only a return or a bus write may turn the global enable back on
  sequence s_taken;
    irq_take ##1 (!return_from_irq && !s_axi_awvalid) [*4];
  endsequence
  property p_take_group; irq_take |-> stack_push && pc_load; endproperty
  a_take_group: assert property (p_take_group) else $error("take without push");
  property p_vector; pc_load |-> pc_load_value == `MIC_VECTOR; endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_push_pc; stack_push |-> stack_push_data == $past(core_pc); endproperty
  a_push_pc: assert property (p_push_pc) else $error("wrong return address");
  property p_take_cause; irq_take |-> $past(irq, 2) || $past(irq, 3); endproperty
  a_take_cause: assert property (p_take_cause) else $error("take not pending");
  property p_gie_cleared; s_taken |-> !irq && !irq_take; endproperty
  a_gie_cleared: assert property (p_gie_cleared) else $error("enable kept");
  property p_reset_quiet; $rose(aresetn) |-> !irq && !irq_take && !wake_up; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_wake_cause; wake_up |-> $past(core_sleeping); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake while awake");
  property p_wr_resp; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read data");
endmodule

//--- testbench/mic_core_model.sv
`timescale 1ns/1ps
module mic_core_model (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // bench requests
  input  wire logic             go_sleep,
  input  wire logic             go_return,
  // controller side
  input  wire logic             stack_push,
  input  wire mic_pkg::mic_pc_t stack_push_data,
  input  wire logic             pc_load,
  input  wire mic_pkg::mic_pc_t pc_load_value,
  input  wire logic             wake_up,
  output logic                  return_from_irq,
  output logic                  core_sleeping,
  output mic_pkg::mic_pc_t      core_pc
);
  import mic_pkg::*;
  mic_pc_t    stack [8];
  logic [2:0] sp;
  // a return on an empty stack would pop junk, so it is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp              <= 3'h0;
      core_pc         <= 13'h0000;
      core_sleeping   <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= go_return && sp != 3'h0;
      core_sleeping   <= go_sleep || (core_sleeping && !wake_up);
      if (stack_push) begin
        stack[sp] <= stack_push_data;
        sp        <= sp + 3'h1;
      end
      if (pc_load) core_pc <= pc_load_value;
      else if (go_return && sp != 3'h0) begin
        core_pc <= stack[sp - 3'h1];
        sp      <= sp - 3'h1;
      end else if (!core_sleeping) core_pc <= core_pc + 13'h0001;
    end
  end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "mic_cfg.svh"
module testbench;
  import mic_pkg::*;
  logic        aclk = 0, aresetn = 0, go_sleep = 0, go_return = 0, ext_irq_pin = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, ga, gw;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, psrc = '0, s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [7:0]  timer8_count = '0, rd;
  logic [5:0]  port_pins = '0, change_detect_select = 6'h04;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        return_from_irq, core_sleeping, irq_take, stack_push, pc_load, wake_up, irq;
  mic_pc_t     core_pc, stack_push_data, pc_load_value;
  int          errors = 0, n_checks = 0, n;
  logic [7:0]  pbit [4] = '{8'h01, 8'h08, 8'h40, 8'h80};
  mic_irq_ctrl u_mic_irq_ctrl (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin, .timer8_count, .port_pins,
    .change_detect_select, .cmp_change(psrc[1]), .adc_done(psrc[2]),
    .timer16_overflow(psrc[0]), .eeprom_write_done(psrc[3]), .return_from_irq,
    .core_sleeping, .core_pc, .irq_take, .stack_push, .stack_push_data, .pc_load,
    .pc_load_value, .wake_up, .irq);
  mic_core_model u_mic_core_model (.aclk, .aresetn, .go_sleep, .go_return, .stack_push,
    .stack_push_data, .pc_load, .pc_load_value, .wake_up, .return_from_irq,
    .core_sleeping, .core_pc);
  initial forever #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    ga = 0;
    gw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      ga |= s_axi_awready;
      gw |= s_axi_wready;
      s_axi_awvalid <= !ga;
      s_axi_wvalid <= !gw;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // idle edge: a following call must not re-raise ready in this step
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // bounded so a missing take shows as a mismatch, not a hang
  task automatic wait_on(input logic wake);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(wake ? wake_up : pc_load) && n < 30);
    if (!wake) chk({stack_push, pc_load, pc_load_value}, {2'h3, `MIC_VECTOR});
  endtask
  task automatic ret;
    go_return <= 1'b1;
    @(posedge aclk);
    go_return <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axw(`MIC_OFF_CONTROL, 8'h80);
    chk(rs, 2'h0);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // byte lane off: the write must leave the register alone
    s_axi_wstrb <= 4'h0;
    axw(`MIC_OFF_CONTROL, 8'h80);
    s_axi_wstrb <= 4'h1;
    axr(`MIC_OFF_CONTROL);
    chk(rd, `MIC_CONTROL_RST);
    axr(`MIC_OFF_OPTION);
    chk(rd, {7'h00, `MIC_EDGE_RST});
    axr(4'h2);
    chk(rs, 2'h2);
    chk(rd, 8'h00);
    axw(4'h2, 8'hFF);
    chk(rs, 2'h2);
  endtask
  task automatic t_ext(input logic rise);
    axw(`MIC_OFF_OPTION, {7'h00, rise});
    axw(`MIC_OFF_CONTROL, 8'h90);
    ext_irq_pin <= rise;
    wait_on(1'b0);
    // pin seen one edge late, pc_load counted one edge late: latency is n - 2
    chk(n >= 5 && n <= 6, 1'b1);
    axr(`MIC_OFF_CONTROL);
    chk(rd, 8'h12);
    axw(`MIC_OFF_CONTROL, 8'h10);
    ret;
    axr(`MIC_OFF_CONTROL);
    chk(rd, 8'h90);
  endtask
  task automatic t_mask;
    axw(`MIC_OFF_CONTROL, 8'h00);
    timer8_count <= 8'hFF;
    @(posedge aclk);
    timer8_count <= 8'h00;
    @(posedge aclk);
    axr(`MIC_OFF_CONTROL);
    chk(rd, 8'h04);
    axw(`MIC_OFF_CONTROL, 8'h84);
    repeat (6) @(posedge aclk);
    chk(irq, 1'b0);
    axw(`MIC_OFF_CONTROL, 8'h24);
    repeat (6) @(posedge aclk);
    chk(irq, 1'b0);
    axw(`MIC_OFF_CONTROL, 8'hA4);
    wait_on(1'b0);
    axw(`MIC_OFF_CONTROL, 8'h20);
    ret;
  endtask
  task automatic t_port;
    axw(`MIC_OFF_CONTROL, 8'h88);
    port_pins <= 6'h08;
    repeat (6) @(posedge aclk);
    chk(irq, 1'b0);
    port_pins <= 6'h0C;
    wait_on(1'b0);
    chk(n >= 5 && n <= 6, 1'b1);
    axr(`MIC_OFF_CONTROL);
    chk(rd, 8'h09);
    axw(`MIC_OFF_CONTROL, 8'h08);
    ret;
  endtask
  task automatic t_src(input int i, input logic g);
    axw(`MIC_OFF_PENABLE, pbit[i]);
    axw(`MIC_OFF_CONTROL, {1'b1 ^ g, g, 6'h00});
    go_sleep <= g;
    @(posedge aclk);
    go_sleep <= 1'b0;
    psrc <= 4'h1 << i;
    @(posedge aclk);
    psrc <= 4'h0;
    wait_on(1'b1);
    chk({wake_up, irq}, {g, 1'b0});
    axr(`MIC_OFF_PFLAGS);
    chk(rd, pbit[i]);
    axw(`MIC_OFF_CONTROL, 8'hC0);
    wait_on(1'b0);
    axw(`MIC_OFF_PFLAGS, 8'h00);
    ret;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_ext(1'b1);
    t_ext(1'b0);
    t_mask;
    t_port;
    for (int i = 0; i < 8; i++) t_src(i % 4, 1'(i / 4));
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test;
  end
endmodule
bind mic_irq_ctrl mic_irq_ctrl_props u_mic_irq_ctrl_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arready, .s_axi_rvalid, .return_from_irq, .core_sleeping, .irq_take,
  .stack_push, .stack_push_data, .core_pc, .pc_load, .pc_load_value, .wake_up, .irq);
